// ### hw/uart_status2_control3.v
// Purpose: Second status and third control registers of the serial port
// Assumes: All inputs synchronous to ref_clk; bitTick from baud generator
// Notes:   Shifters, data register and first status flags sit outside
`timescale 1ns/1ns
`include "uart_status2_control3_defines.vh"
module uart_status2_control3 (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        clkEn,
  // Register port
  input  wire [1:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdData,
  // Shared configuration and timing
  input  wire        nineBitMode,
  input  wire        bitTick,
  // Receive side
  input  wire        rxPin,
  output reg         rxData,
  input  wire        rxStartDetect,
  input  wire        rxIdleDetect,
  input  wire        rxStandby,
  output wire        idleFlagSet,
  input  wire        rxFramingSet,
  input  wire        rxFullSet,
  output wire        framingSetGated,
  output wire        fullSetGated,
  input  wire        rxNinthIn,
  input  wire        rxLoad,
  output reg         rxBreakDetect,
  // Error flags and request
  input  wire        overrunFlag,
  input  wire        noiseFlag,
  input  wire        framingErrFlag,
  input  wire        parityErrFlag,
  output reg         errIrq,
  // Transmit side
  input  wire        txLoad,
  input  wire [7:0]  txDataIn,
  output reg  [10:0] txShiftWord,
  output reg  [3:0]  txFrameLen,
  input  wire        txBreakReq,
  output reg         txBreakActive,
  input  wire        txSerial,
  input  wire        loopbackSelect,
  input  wire        rxSourceSelect,
  output reg         txPinOut,
  output reg         txPinOe
);

  // ********************************************************
  // Declarations
  // ********************************************************
  reg        rxInvert_reg;
  reg        idleReport_reg;
  reg        longBreak_reg;
  reg        linDetect_reg;
  reg        rxActive_reg;
  reg        rxNinth_reg;
  reg        txNinth_reg;
  reg        direction_reg;
  reg        txInvert_reg;
  reg [3:0]  errEnable_reg;
  reg        rxPrev_reg;
  reg        rxDataPrimed_reg;
  wire       breakFlag;
  wire       edgeFlag;
  wire       wrStatus;
  wire       wrControl;
  wire       rxCorrected;
  wire       rxEdge;
  wire       rxBreakHit;
  wire       txBreakDone;
  wire       singleWire;
  wire       txBreakStart;
  wire [3:0] rxBreakLen;
  wire [3:0] txBreakLen;
  wire [3:0] errRequest;
  reg  [7:0] rdMux;

  assign wrStatus  = regWrite & (regAddr == `STATUS_TWO_ADDR);
  assign wrControl = regWrite & (regAddr == `CONTROL_THREE_ADDR);

  // ********************************************************
  // Software-written fields
  // ********************************************************
  // Ninth receive bit and both flags are not software-writable here
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxInvert_reg   <= 1'b0;
      idleReport_reg <= 1'b0;
      longBreak_reg  <= 1'b0;
      linDetect_reg  <= 1'b0;
      txNinth_reg    <= 1'b0;
      direction_reg  <= 1'b0;
      txInvert_reg   <= 1'b0;
      errEnable_reg  <= 4'h0;
    end else if (clkEn) begin
      if (wrStatus) begin
        rxInvert_reg   <= regWrData[`S2_RX_INVERT];
        idleReport_reg <= regWrData[`S2_IDLE_REPORT];
        longBreak_reg  <= regWrData[`S2_LONG_BREAK];
        linDetect_reg  <= regWrData[`S2_LIN_DETECT];
      end
      if (wrControl) begin
        txNinth_reg    <= regWrData[`C3_TX_NINTH]; // Kept until rewritten
        direction_reg  <= regWrData[`C3_DIRECTION];
        txInvert_reg   <= regWrData[`C3_TX_INVERT];
        errEnable_reg  <= regWrData[`C3_OVERRUN_EN:`C3_PARITY_EN];
      end
    end
  end

  // ********************************************************
  // Receive polarity and edge detection
  // ********************************************************
  // One inversion point feeds data, start, stop, break and idle alike
  assign rxCorrected = rxPin ^ rxInvert_reg;
  // Raw pin change landing on the active level; an inversion toggle is no edge
  assign rxEdge = rxDataPrimed_reg & (rxPrev_reg ^ rxPin) & ~rxCorrected;

  // Registered line for the receiver, plus previous raw pin
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxData           <= 1'b1;
      rxPrev_reg       <= 1'b1;
      rxDataPrimed_reg <= 1'b0;
    end else if (clkEn) begin
      rxData           <= rxCorrected;
      rxPrev_reg       <= rxPin;
      rxDataPrimed_reg <= 1'b1; // No edge on the very first sample
    end
  end

  sticky_flag edgeFlagInst (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .setPulse   (rxEdge),
    .clearPulse (wrStatus & regWrData[`S2_EDGE_FLAG]),
    .flag_reg   (edgeFlag)
  );

  // ********************************************************
  // Receive break detection
  // ********************************************************
  // Threshold grows by one with LIN detect and by one in nine-bit mode
  assign rxBreakLen = (linDetect_reg ? `RX_BREAK_LIN : `RX_BREAK_NORMAL)
                    + {3'h0, nineBitMode};

  // Counts consecutive low bit times; any high level restarts
  bit_time_counter rxBreakCount (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .restart (rxCorrected),
    .countOn (1'b1),
    .tick    (bitTick),
    .length  (rxBreakLen),
    .reached (rxBreakHit)
  );

  // Break pulse to the receiver, registered
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBreakDetect <= 1'b0;
    end else if (clkEn) begin
      rxBreakDetect <= rxBreakHit;
    end
  end

  sticky_flag breakFlagInst (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .setPulse   (rxBreakHit & linDetect_reg),
    .clearPulse (wrStatus & regWrData[`S2_BREAK_FLAG]),
    .flag_reg   (breakFlag)
  );

  // ********************************************************
  // Receiver flag steering
  // ********************************************************
  // Long-break select deliberately absent: framing check is unaffected
  assign framingSetGated = rxFramingSet & ~linDetect_reg;
  assign fullSetGated    = rxFullSet & ~linDetect_reg;
  // Waking idle reports only when asked to while in standby
  assign idleFlagSet = rxIdleDetect & (~rxStandby | idleReport_reg);

  // Active flag: start sets, idle clears; start wins on a tie
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxActive_reg <= 1'b0;
    end else if (clkEn) begin
      if (rxStartDetect) begin
        rxActive_reg <= 1'b1;
      end else if (rxIdleDetect) begin
        rxActive_reg <= 1'b0;
      end
    end
  end

  // Ninth receive bit follows each transfer into the data buffer in nine-bit mode
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxNinth_reg <= 1'b0;
    end else if (clkEn) begin
      if (rxLoad && nineBitMode) begin
        rxNinth_reg <= rxNinthIn;
      end
    end
  end

  // ********************************************************
  // Error interrupt request
  // ********************************************************
  // Level stays up while any enabled flag stays set
  assign errRequest = {overrunFlag, noiseFlag, framingErrFlag, parityErrFlag}
                    & errEnable_reg;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      errIrq <= 1'b0;
    end else if (clkEn) begin
      errIrq <= |errRequest;
    end
  end

  // ********************************************************
  // Transmit word assembly
  // ********************************************************
  // Frame: start 0, data LSB first, optional ninth bit, stop 1
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShiftWord <= 11'h7FF;
      txFrameLen  <= `FRAME_LEN_EIGHT;
    end else if (clkEn) begin
      if (txLoad) begin
        if (nineBitMode) begin
          txShiftWord <= {1'b1, txNinth_reg, txDataIn, 1'b0};
          txFrameLen  <= `FRAME_LEN_NINE;
        end else begin
          txShiftWord <= {2'h3, txDataIn, 1'b0};
          txFrameLen  <= `FRAME_LEN_EIGHT;
        end
      end
    end
  end

  // ********************************************************
  // Transmit break generation
  // ********************************************************
  assign txBreakLen = (longBreak_reg ? `TX_BREAK_LONG : `TX_BREAK_SHORT)
                    + {3'h0, nineBitMode};
  assign txBreakStart = txBreakReq & ~txBreakActive;

  bit_time_counter txBreakCount (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .restart (txBreakStart),
    .countOn (txBreakActive),
    .tick    (bitTick),
    .length  (txBreakLen),
    .reached (txBreakDone)
  );

  // Request during a break is ignored; the shifter queues the next
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txBreakActive <= 1'b0;
    end else if (clkEn) begin
      if (txBreakStart) begin
        txBreakActive <= 1'b1;
      end else if (txBreakDone) begin
        txBreakActive <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Transmit pin
  // ********************************************************
  assign singleWire = loopbackSelect & rxSourceSelect;

  // Inversion applies after break forcing so break is inverted too
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txPinOut <= 1'b1;
      txPinOe  <= 1'b1;
    end else if (clkEn) begin
      txPinOut <= (txSerial & ~txBreakActive) ^ txInvert_reg;
      txPinOe  <= ~singleWire | direction_reg;
    end
  end

  // ********************************************************
  // Register read
  // ********************************************************
  always @* begin
    rdMux = 8'h00;
    case (regAddr)
      `STATUS_TWO_ADDR: begin
        rdMux[`S2_BREAK_FLAG]  = breakFlag;
        rdMux[`S2_EDGE_FLAG]   = edgeFlag;
        rdMux[`S2_RX_INVERT]   = rxInvert_reg;
        rdMux[`S2_IDLE_REPORT] = idleReport_reg;
        rdMux[`S2_LONG_BREAK]  = longBreak_reg;
        rdMux[`S2_LIN_DETECT]  = linDetect_reg;
        rdMux[`S2_RX_ACTIVE]   = rxActive_reg;
      end
      `CONTROL_THREE_ADDR: begin
        rdMux[`C3_RX_NINTH]    = rxNinth_reg;
        rdMux[`C3_TX_NINTH]    = txNinth_reg;
        rdMux[`C3_DIRECTION]   = direction_reg;
        rdMux[`C3_TX_INVERT]   = txInvert_reg;
        rdMux[`C3_OVERRUN_EN:`C3_PARITY_EN] = errEnable_reg;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe, else zero
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (clkEn) begin
      regRdData <= regRead ? rdMux : 8'h00;
    end
  end

endmodule // uart_status2_control3

// ### hw/uart_status2_control3_defines.vh
// Purpose: Constants for the second status and third control register block
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are register addresses on the plain register port
//
// Summary of operation
// - Break seen with detect enabled sets flag
// - Active receive edge sets edge flag
// - Receive inversion flips every received line element
// - Standby idle sets idle only when reporting
// - Sent break 10 or 13, plus nine-bit
// - Long break never alters framing error detection
// - Receive break threshold 10/11, plus nine-bit
// - Detect enabled blocks framing and full flags
// - Start sets active flag, idle clears it
// - Ninth received bit readable, read-only
// - Data write sends full nine-bit value
// - Direction bit sets single-wire pin direction
// - Transmit inversion flips transmit output
// - Overrun and enable raise request
// - Noise and enable raise request
// - Framing error and enable raise request
// - Parity error and enable raise request
// - Shifter holds 10 or 11 bits
`ifndef UART_STATUS2_CONTROL3_DEFINES_VH
`define UART_STATUS2_CONTROL3_DEFINES_VH

// ********************************************************
// Register addresses
// ********************************************************
`define STATUS_TWO_ADDR    2'h0
`define CONTROL_THREE_ADDR 2'h1

// ********************************************************
// Field positions, second status register
// ********************************************************
`define S2_BREAK_FLAG   7
`define S2_EDGE_FLAG    6
`define S2_RX_INVERT    4
`define S2_IDLE_REPORT  3
`define S2_LONG_BREAK   2
`define S2_LIN_DETECT   1
`define S2_RX_ACTIVE    0

// ********************************************************
// Field positions, third control register
// ********************************************************
`define C3_RX_NINTH     7
`define C3_TX_NINTH     6
`define C3_DIRECTION    5
`define C3_TX_INVERT    4
`define C3_OVERRUN_EN   3
`define C3_NOISE_EN     2
`define C3_FRAMING_EN   1
`define C3_PARITY_EN    0

// ********************************************************
// Reset values
// ********************************************************
`define STATUS_TWO_RESET    8'h00
`define CONTROL_THREE_RESET 8'h00

// ********************************************************
// Bit-time counts
// ********************************************************
`define TX_BREAK_SHORT   4'hA
`define TX_BREAK_LONG    4'hD
`define RX_BREAK_NORMAL  4'hA
`define RX_BREAK_LIN     4'hB
`define FRAME_LEN_EIGHT  4'hA
`define FRAME_LEN_NINE   4'hB

`endif

// ### hw/sticky_flag.v
// Purpose: Hardware-set, write-one-to-clear status flag
// Assumes: Set and clear are one-cycle pulses on ref_clk
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ns
module sticky_flag (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire clkEn,
  input  wire setPulse,
  input  wire clearPulse,
  output reg  flag_reg
);

  // ********************************************************
  // Flag storage
  // ********************************************************
  // Set checked first so an event is never lost to a clear
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (clkEn) begin
      if (setPulse) begin
        flag_reg <= 1'b1;
      end else if (clearPulse) begin
        flag_reg <= 1'b0;
      end
    end
  end

endmodule // sticky_flag

// ### hw/bit_time_counter.v
// Purpose: Counts bit-time ticks and pulses when a length is reached
// Assumes: tick is one cycle per bit time
// Notes:   Saturates after reaching the length; restart clears it
`timescale 1ns/1ns
module bit_time_counter (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clkEn,
  input  wire       restart,
  input  wire       countOn,
  input  wire       tick,
  input  wire [3:0] length,
  output wire       reached
);

  reg  [3:0] count_reg;
  wire       atEnd;

  // Pulse on the tick that completes the length
  assign atEnd   = (count_reg == length - 4'h1);
  assign reached = countOn & tick & atEnd & ~restart;

  // ********************************************************
  // Tick counter
  // ********************************************************
  // Stops one past the end so the pulse fires only once
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 4'h0;
    end else if (clkEn) begin
      if (restart) begin
        count_reg <= 4'h0;
      end else if (countOn && tick && (count_reg != length)) begin
        count_reg <= count_reg + 4'h1;
      end
    end
  end

endmodule // bit_time_counter

// ### dv/uart_status2_control3_chk.sv
// Purpose: Port-level assertions for uart_status2_control3
// Assumes: One clock domain; clkEn drops only while the ports are idle
// Notes:   Attached to every instance of the block by the bind below
`timescale 1ns/1ns
module uart_status2_control3_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       bitTick,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic       rxStandby,
  input wire logic       rxIdleDetect,
  input wire logic       idleFlagSet,
  input wire logic       rxFramingSet,
  input wire logic       rxFullSet,
  input wire logic       framingSetGated,
  input wire logic       fullSetGated,
  input wire logic       rxBreakDetect,
  input wire logic       overrunFlag,
  input wire logic       noiseFlag,
  input wire logic       framingErrFlag,
  input wire logic       parityErrFlag,
  input wire logic       errIrq,
  input wire logic       loopbackSelect,
  input wire logic       rxSourceSelect,
  input wire logic       txPinOe,
  input wire logic       txBreakReq,
  input wire logic       txBreakActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Any error flag up, sampled a cycle later for the request check
  wire anyFlag = overrunFlag | noiseFlag | framingErrFlag | parityErrFlag;

  // Ticks inside a sent break; cleared between breaks so lengths never add up
  logic [4:0] brkTicks_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) brkTicks_reg <= 5'h00;
    else if (!txBreakActive) brkTicks_reg <= 5'h00;
    else if (bitTick) brkTicks_reg <= brkTicks_reg + 5'h01;
  end

  AST_RD_IDLE: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside the read slot");
  AST_FE_GATE: assert property (framingSetGated |-> rxFramingSet)
    else $error("framing set without cause");
  AST_FULL_GATE: assert property (fullSetGated |-> rxFullSet)
    else $error("full set without cause");
  AST_IDLE_GATE: assert property (idleFlagSet |-> rxIdleDetect)
    else $error("idle set without idle line");
  AST_IDLE_AWAKE: assert property (rxIdleDetect && !rxStandby |-> idleFlagSet)
    else $error("idle lost while awake");
  AST_IRQ_CAUSE: assert property (errIrq |-> $past(anyFlag))
    else $error("error request without flag");
  AST_OE_FULL: assert property (!(loopbackSelect && rxSourceSelect) |=> txPinOe)
    else $error("pin not driven outside single wire");
  AST_BRK_START: assert property (txBreakReq && !txBreakActive |=> txBreakActive)
    else $error("break did not start");
  AST_BRK_LEN: assert property ($fell(txBreakActive) |-> brkTicks_reg inside {5'hA, 5'hB, 5'hD, 5'hE})
    else $error("break length wrong");
  AST_RXBRK_TICK: assert property (rxBreakDetect |-> $past(bitTick) && !$past(rxBreakDetect))
    else $error("break detect off the bit tick");
endmodule // uart_status2_control3_chk

bind uart_status2_control3 uart_status2_control3_chk chk_u (
  .ref_clk, .rst_n, .bitTick, .regRead, .regRdData, .rxStandby, .rxIdleDetect,
  .idleFlagSet, .rxFramingSet, .rxFullSet, .framingSetGated, .fullSetGated,
  .rxBreakDetect, .overrunFlag, .noiseFlag, .framingErrFlag, .parityErrFlag,
  .errIrq, .loopbackSelect, .rxSourceSelect, .txPinOe, .txBreakReq, .txBreakActive
);

// ### dv/remote_node_model.sv
// Purpose: Remote serial node driving the receive line
// Assumes: Line idles high through a pull-up; a bit time is TICK_DIV cycles
// Notes:   Called just after a clock edge; holdLow releases the line to idle, setLine holds its level
`timescale 1ns/1ns
module remote_node_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic ref_clk,
  output logic      rxLine
);
  initial rxLine = 1'b1;

  // Level change, held until the next call
  task automatic setLine(input logic v);
    rxLine <= v;
  endtask

  // Low for whole bit times, then back to the idle level
  task automatic holdLow(input int n);
    rxLine <= 1'b0;
    repeat (TICK_DIV * n) begin
      @(posedge ref_clk);
      #1;
    end
    rxLine <= 1'b1;
  endtask
endmodule // remote_node_model

// ### dv/uart_status2_control3_bench.sv
// Purpose: Self-checking bench for uart_status2_control3
// Assumes: bitTick every 4 cycles; txSerial held high; clkEn low once
// Notes:   Register, receive break and sent break cases run from tables, the rest by hand
`timescale 1ns/1ns
`include "uart_status2_control3_defines.vh"
module uart_status2_control3_bench;
  typedef struct packed { logic [1:0] a; logic [7:0] d; logic [7:0] e; } regRow_t;
  typedef struct packed { logic [7:0] cfg; logic nine; logic [3:0] n; logic hit; } rxRow_t;
  typedef struct packed { logic [7:0] cfg; logic [7:0] c3; logic nine; logic [4:0] n; } txRow_t;
  logic        ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, bitTick = 1'b0;
  logic [1:0]  regAddr = 2'h0, tickDiv = 2'h0;
  logic [7:0]  regWrData = 8'h00, txDataIn = 8'h00, regRdData;
  logic        regWrite = 1'b0, regRead = 1'b0, nineBitMode = 1'b0, txSerial = 1'b1;
  logic        rxStartDetect = 1'b0, rxIdleDetect = 1'b0, rxStandby = 1'b0, rxLoad = 1'b0;
  logic        rxFramingSet = 1'b0, rxFullSet = 1'b0, rxNinthIn = 1'b0, txLoad = 1'b0;
  logic        txBreakReq = 1'b0, loopbackSelect = 1'b0, rxSourceSelect = 1'b0;
  logic [3:0]  errFlags = 4'h0, txFrameLen;
  logic [10:0] txShiftWord;
  logic        rxPin, rxData, idleFlagSet, framingSetGated, fullSetGated, rxBreakDetect;
  logic        errIrq, txBreakActive, txPinOut, txPinOe;
  int          n_errors = 0, cmp_count = 0, txTicks = 0, brkSeen = 0;
  regRow_t regRows [6] = '{'{2'h0, 8'hEF, 8'h0E}, '{2'h1, 8'hFF, 8'h7F},
    '{2'h2, 8'hFF, 8'h00}, '{2'h3, 8'h5A, 8'h00}, '{2'h0, 8'h00, 8'h00}, '{2'h1, 8'h00, 8'h00}};
  rxRow_t rxRows [9] = '{'{8'h00, 1'b0, 4'h9, 1'b0}, '{8'h00, 1'b0, 4'hA, 1'b1},
    '{8'h04, 1'b0, 4'hA, 1'b1}, '{8'h02, 1'b0, 4'hA, 1'b0}, '{8'h02, 1'b0, 4'hB, 1'b1},
    '{8'h00, 1'b1, 4'hA, 1'b0}, '{8'h00, 1'b1, 4'hB, 1'b1}, '{8'h02, 1'b1, 4'hB, 1'b0},
    '{8'h02, 1'b1, 4'hC, 1'b1}};
  txRow_t txRows [4] = '{'{8'h00, 8'h00, 1'b0, 5'hA}, '{8'h04, 8'h00, 1'b0, 5'hD},
    '{8'h00, 8'h10, 1'b1, 5'hB}, '{8'h04, 8'h10, 1'b1, 5'hE}};

  uart_status2_control3 dut_u (.ref_clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .nineBitMode, .bitTick, .rxPin, .rxData, .rxStartDetect,
    .rxIdleDetect, .rxStandby, .idleFlagSet, .rxFramingSet, .rxFullSet, .framingSetGated,
    .fullSetGated, .rxNinthIn, .rxLoad, .rxBreakDetect, .overrunFlag(errFlags[3]),
    .noiseFlag(errFlags[2]), .framingErrFlag(errFlags[1]), .parityErrFlag(errFlags[0]),
    .errIrq, .txLoad, .txDataIn, .txShiftWord, .txFrameLen, .txBreakReq, .txBreakActive,
    .txSerial, .loopbackSelect, .rxSourceSelect, .txPinOut, .txPinOe);
  remote_node_model node_u (.ref_clk(ref_clk), .rxLine(rxPin));

  // ****************************************
  // Clock, bit tick and event counters
  // ****************************************
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tickDiv <= tickDiv + 2'h1;
    bitTick <= (tickDiv == 2'h3);
    if (bitTick && txBreakActive) txTicks <= txTicks + 1;
    if (rxBreakDetect) brkSeen <= brkSeen + 1;
  end

  // Every step lands 1 ns after an edge, so no sampling race
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    tick();
    regWrite <= 1'b0;
    tick();
  endtask
  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    tick();
    regRead <= 1'b0;
    d = regRdData;
    tick();
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ld(input logic [7:0] d);
    txDataIn <= d;
    txLoad <= 1'b1;
    tick();
    txLoad <= 1'b0;
    tick();
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    int b0, k;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick();
    chk("txShiftWord", txShiftWord, 11'h7FF);
    chk("txFrameLen", txFrameLen, 4'hA);
    chk("pins", {txPinOut, txPinOe, rxData}, 3'h7);
    for (int a = 0; a < 2; a++) begin
      rd(a[1:0], v);
      chk("resetRead", v, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      wr(regRows[i].a, regRows[i].d);
      rd(regRows[i].a, v);
      chk("regRead", v, regRows[i].e);
    end
    // Active edge, plain then inverted
    node_u.setLine(1'b0);
    tick();
    tick();
    chk("rxData", rxData, 1'b0);
    rd(`STATUS_TWO_ADDR, v);
    chk("edgeFlag", v, 8'h40);
    wr(`STATUS_TWO_ADDR, 8'h50);
    node_u.setLine(1'b1);
    tick();
    tick();
    chk("rxDataInv", rxData, 1'b0);
    rd(`STATUS_TWO_ADDR, v);
    chk("edgeFlagInv", v, 8'h50);
    wr(`STATUS_TWO_ADDR, 8'h40);
    rd(`STATUS_TWO_ADDR, v);
    chk("edgeClear", v, 8'h00);
    // Receive break thresholds and flag gating
    for (int i = 0; i < 9; i++) begin
      wr(`STATUS_TWO_ADDR, rxRows[i].cfg);
      nineBitMode <= rxRows[i].nine;
      rxFramingSet <= 1'b1;
      rxFullSet <= 1'b1;
      tick();
      chk("feGate", framingSetGated, !rxRows[i].cfg[1]);
      chk("fullGate", fullSetGated, !rxRows[i].cfg[1]);
      rxFramingSet <= 1'b0;
      rxFullSet <= 1'b0;
      b0 = brkSeen;
      node_u.holdLow(rxRows[i].n);
      repeat (8) tick();
      chk("rxBreak", brkSeen - b0, rxRows[i].hit);
      rd(`STATUS_TWO_ADDR, v);
      chk("breakFlag", v[7], rxRows[i].hit & rxRows[i].cfg[1]);
      wr(`STATUS_TWO_ADDR, 8'hC0);
    end
    nineBitMode <= 1'b0;
    // Receiver active and standby idle report
    rxStartDetect <= 1'b1;
    tick();
    rxStartDetect <= 1'b0;
    rd(`STATUS_TWO_ADDR, v);
    chk("rxActive", v, 8'h01);
    for (int r = 0; r < 2; r++) begin
      wr(`STATUS_TWO_ADDR, r ? 8'h08 : 8'h00);
      rxStandby <= 1'b1;
      rxIdleDetect <= 1'b1;
      #1;
      chk("idleSet", idleFlagSet, r[0]);
      tick();
      rxIdleDetect <= 1'b0;
      rd(`STATUS_TWO_ADDR, v);
      chk("rxActiveIdle", v[0], 1'b0);
    end
    rxStandby <= 1'b0;
    // Error request per flag and enable
    for (int i = 0; i < 4; i++) begin
      wr(`CONTROL_THREE_ADDR, 8'h01 << i);
      errFlags <= 4'h1 << i;
      tick();
      tick();
      chk("irqOn", errIrq, 1'b1);
      errFlags <= ~(4'h1 << i);
      tick();
      tick();
      chk("irqOff", errIrq, 1'b0);
    end
    errFlags <= 4'h0;
    // Ninth bit written before the data word
    wr(`CONTROL_THREE_ADDR, 8'h40);
    nineBitMode <= 1'b1;
    ld(8'hA5);
    chk("word9", txShiftWord, 11'h74A);
    chk("len9", txFrameLen, 4'hB);
    wr(`CONTROL_THREE_ADDR, 8'h00);
    ld(8'hA5);
    chk("word9z", txShiftWord, 11'h54A);
    nineBitMode <= 1'b0;
    ld(8'hA5);
    chk("word8", txShiftWord, 11'h74A);
    chk("len8", txFrameLen, 4'hA);
    // Received ninth bit is read-only
    nineBitMode <= 1'b1;
    rxNinthIn <= 1'b1;
    rxLoad <= 1'b1;
    tick();
    rxLoad <= 1'b0;
    rxNinthIn <= 1'b0;
    wr(`CONTROL_THREE_ADDR, 8'h00);
    rd(`CONTROL_THREE_ADDR, v);
    chk("rxNinth", v, 8'h80);
    // Sent break length and polarity
    for (int i = 0; i < 4; i++) begin
      wr(`STATUS_TWO_ADDR, txRows[i].cfg);
      wr(`CONTROL_THREE_ADDR, txRows[i].c3);
      nineBitMode <= txRows[i].nine;
      txBreakReq <= 1'b1;
      tick();
      txBreakReq <= 1'b0;
      b0 = txTicks;
      tick();
      chk("breakLevel", txPinOut, txRows[i].c3[4]);
      for (k = 0; k < 80 && txBreakActive === 1'b1; k++) tick();
      if (k == 80) begin
        n_errors++;
        give_verdict();
      end
      chk("breakTicks", txTicks - b0, txRows[i].n);
      tick();
      chk("idleLevel", txPinOut, !txRows[i].c3[4]);
    end
    // Single-wire direction
    loopbackSelect <= 1'b1;
    rxSourceSelect <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      wr(`CONTROL_THREE_ADDR, d ? 8'h20 : 8'h00);
      tick();
      chk("pinDir", txPinOe, d[0]);
    end
    // Frozen clock enable: the write is ignored, direction kept
    clkEn <= 1'b0;
    wr(`CONTROL_THREE_ADDR, 8'h00);
    clkEn <= 1'b1;
    tick();
    chk("freeze", txPinOe, 1'b1);
    give_verdict();
  end
endmodule // uart_status2_control3_bench
